// ### design/mcd_consts.svh
`ifndef MCD_CONSTS_SVH
`define MCD_CONSTS_SVH

// register byte addresses
`define MCD_ADDR_CTRL        8'h00
`define MCD_ADDR_HOME_SPEED  8'h04
`define MCD_ADDR_HOME_ACCEL  8'h08
`define MCD_ADDR_HOME_OFFSET 8'h0c
`define MCD_ADDR_HOME_DIR    8'h10
`define MCD_ADDR_JOG_SPEED   8'h14
`define MCD_ADDR_JOG_ACCEL   8'h18
`define MCD_ADDR_JOG_TORQUE  8'h1c
`define MCD_ADDR_JOG_TRAVEL  8'h20
`define MCD_ADDR_PRESET_POS  8'h24
`define MCD_ADDR_DIRECT_MAP  8'h28
`define MCD_ADDR_STATUS      8'h2c
`define MCD_ADDR_CMD_POS     8'h30

// control register fields
`define MCD_CTRL_POS_BIT     0
`define MCD_CTRL_COMPAT_BIT  1
`define MCD_CTRL_MAP_LSB     8
`define MCD_CTRL_MAP_MSB     15

// ranges and reset values
`define MCD_SPEED_MAX        32'h0000_0fa0
`define MCD_SPEED_RST        13'h12c
`define MCD_ACCEL_MAX        32'h0000_7530
`define MCD_ACCEL_RST        15'h064
`define MCD_TORQUE_MAX       32'h0000_00fa
`define MCD_TORQUE_RST       8'h64
`define MCD_TRAVEL_MIN       32'h0000_0001
`define MCD_TRAVEL_MAX       32'h007f_ffff
`define MCD_TRAVEL_RST       23'h000001
`define MCD_POS_RST          24'h000000
`define MCD_HOME_DIR_RST     1'h1
`define MCD_DIRECT_MAP_RST   24'h543210
`define MCD_DATA_NO_W        4
`define MCD_DIRECT_COUNT     6
`define MCD_TERM_COUNT       8

`endif

// ### design/mcd_pkg.sv
package mcd_pkg;

    typedef enum logic [2:0]
    {
        MCD_CMD_NONE       = 3'b000,
        MCD_CMD_POSITION   = 3'b001,
        MCD_CMD_HOME       = 3'b010,
        MCD_CMD_SEQUENTIAL = 3'b011,
        MCD_CMD_DIRECT     = 3'b100,
        MCD_CMD_JOG        = 3'b101
    } mcd_cmd_kind_type;

    // raw input terminals as they arrive from the host controller
    typedef struct packed
    {
        logic [7:0] tool_terms;
        logic [3:0] op_select;
        logic       start;
        logic       home_start;
        logic       home_sensor;
        logic       sequential_start;
        logic [5:0] direct_select_inputs;
        logic       jog_positive;
        logic       jog_negative;
        logic       position_load;
        logic       free_run;
    } mcd_pins_type;

    // one motion request to the profile generator
    typedef struct packed
    {
        logic             valid;
        mcd_cmd_kind_type kind;
        logic [3:0]       data_no;
        logic             dir_positive;
        logic [12:0]      speed;
        logic [14:0]      accel_ms;
        logic [7:0]       torque_pct;
        logic [22:0]      travel;
        logic [23:0]      offset;
    } mcd_cmd_type;

    // status outputs, each gated by the position mode bit or the compat mode bit
    typedef struct packed
    {
        logic ready;
        logic home_position;
        logic end_done;
        logic torque_limit_reached;
        logic legacy_torque_limit_flag;
    } mcd_outs_type;

endpackage : mcd_pkg

// ### design/mcd_top.sv
// The placing of the registers and the strobed register port were left to the implementer.
`include "mcd_consts.svh"

module mcd_top
    import mcd_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire mcd_pins_type pins,
    input  wire logic         alarm_flag,
    input  wire logic         motor_moving,
    input  wire logic         motion_done,
    input  wire logic         torque_at_limit,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_write,
    input  wire logic         reg_read,
    output logic [31:0]       reg_rdata,
    output mcd_cmd_type       motion_cmd,
    output logic              home_sensor_active,
    output logic              tool_functions_allowed,
    output mcd_outs_type      status_outs
);

    // saturate a written value into its legal range
    function automatic logic [31:0] mcd_clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] r;
        r = v;
        if (v < lo)
            r = lo;
        if (v > hi)
            r = hi;
        return r;
    endfunction : mcd_clamp

    // lowest asserted direct select line wins when several rise together
    function automatic logic [2:0] mcd_first(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = `MCD_DIRECT_COUNT - 1; i >= 0; i--)
            if (v[i])
                idx = 3'(i);
        return idx;
    endfunction : mcd_first

    logic                  pos_mode;
    logic                  compat_mode;
    logic [7:0]            unlock_map;
    logic [12:0]           home_speed;
    logic [14:0]           home_accel;
    logic [23:0]           home_offset;
    logic                  home_dir;
    logic [12:0]           jog_speed;
    logic [14:0]           jog_accel;
    logic [7:0]            jog_torque;
    logic [22:0]           jog_travel;
    logic [23:0]           preset_pos;
    logic [23:0]           direct_map;
    logic [23:0]           cmd_pos;
    logic [3:0]            seq_no;
    logic                  home_active;
    logic                  home_established;
    mcd_pins_type          sync1;
    mcd_pins_type          sync2;
    mcd_pins_type          sync3;
    mcd_pins_type          filt;
    mcd_pins_type          filt_d;
    mcd_pins_type          rise;
    logic                  may_start;
    logic                  any_start_level;
    logic [3:0]            ms_no;
    mcd_cmd_type           next_cmd;
    logic                  pload_ok;

    // three stage input capture; a change counts once stages two and three agree
    always_ff @(posedge clk)
    begin
        sync1 <= pins;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            filt   <= '0;
            filt_d <= '0;
        end
        else
        begin
            for (int b = 0; b < $bits(mcd_pins_type); b++)
                if (sync2[b] == sync3[b])
                    filt[b] <= sync3[b];
            filt_d <= filt;
        end
    end

    assign rise = filt & ~filt_d;

    // register writes; speed, acceleration, torque and travel are clamped into range, offsets, direction and maps are not
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pos_mode    <= 1'b0;
            compat_mode <= 1'b0;
            unlock_map  <= 8'h00;
            home_speed  <= `MCD_SPEED_RST;
            home_accel  <= `MCD_ACCEL_RST;
            home_offset <= `MCD_POS_RST;
            home_dir    <= `MCD_HOME_DIR_RST;
            jog_speed   <= `MCD_SPEED_RST;
            jog_accel   <= `MCD_ACCEL_RST;
            jog_torque  <= `MCD_TORQUE_RST;
            jog_travel  <= `MCD_TRAVEL_RST;
            preset_pos  <= `MCD_POS_RST;
            direct_map  <= `MCD_DIRECT_MAP_RST;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                `MCD_ADDR_CTRL:
                begin
                    pos_mode    <= reg_wdata[`MCD_CTRL_POS_BIT];
                    compat_mode <= reg_wdata[`MCD_CTRL_COMPAT_BIT];
                    unlock_map  <= reg_wdata[`MCD_CTRL_MAP_MSB:`MCD_CTRL_MAP_LSB];
                end
                `MCD_ADDR_HOME_SPEED:  home_speed  <= 13'(mcd_clamp(reg_wdata, 32'h0, `MCD_SPEED_MAX));
                `MCD_ADDR_HOME_ACCEL:  home_accel  <= 15'(mcd_clamp(reg_wdata, 32'h0, `MCD_ACCEL_MAX));
                `MCD_ADDR_HOME_OFFSET: home_offset <= reg_wdata[23:0];
                `MCD_ADDR_HOME_DIR:    home_dir    <= reg_wdata[0];
                `MCD_ADDR_JOG_SPEED:   jog_speed   <= 13'(mcd_clamp(reg_wdata, 32'h0, `MCD_SPEED_MAX));
                `MCD_ADDR_JOG_ACCEL:   jog_accel   <= 15'(mcd_clamp(reg_wdata, 32'h0, `MCD_ACCEL_MAX));
                `MCD_ADDR_JOG_TORQUE:  jog_torque  <= 8'(mcd_clamp(reg_wdata, 32'h0, `MCD_TORQUE_MAX));
                `MCD_ADDR_JOG_TRAVEL:  jog_travel  <= 23'(mcd_clamp(reg_wdata, `MCD_TRAVEL_MIN, `MCD_TRAVEL_MAX));
                `MCD_ADDR_PRESET_POS:  preset_pos  <= reg_wdata[23:0];
                `MCD_ADDR_DIRECT_MAP:  direct_map  <= reg_wdata[23:0];
                default:
                begin
                end
            endcase
        end
    end

    // read data stands in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 32'h0;
        else if (reg_read)
        begin
            unique case (reg_addr)
                `MCD_ADDR_CTRL:        reg_rdata <= {16'h0, unlock_map, 6'h0, compat_mode, pos_mode};
                `MCD_ADDR_HOME_SPEED:  reg_rdata <= {19'h0, home_speed};
                `MCD_ADDR_HOME_ACCEL:  reg_rdata <= {17'h0, home_accel};
                `MCD_ADDR_HOME_OFFSET: reg_rdata <= {{8{home_offset[23]}}, home_offset};
                `MCD_ADDR_HOME_DIR:    reg_rdata <= {31'h0, home_dir};
                `MCD_ADDR_JOG_SPEED:   reg_rdata <= {19'h0, jog_speed};
                `MCD_ADDR_JOG_ACCEL:   reg_rdata <= {17'h0, jog_accel};
                `MCD_ADDR_JOG_TORQUE:  reg_rdata <= {24'h0, jog_torque};
                `MCD_ADDR_JOG_TRAVEL:  reg_rdata <= {9'h0, jog_travel};
                `MCD_ADDR_PRESET_POS:  reg_rdata <= {{8{preset_pos[23]}}, preset_pos};
                `MCD_ADDR_DIRECT_MAP:  reg_rdata <= {8'h0, direct_map};
                `MCD_ADDR_STATUS:      reg_rdata <= {24'h0, seq_no, 1'b0, home_active, home_established,
                                                     tool_functions_allowed};
                `MCD_ADDR_CMD_POS:     reg_rdata <= {{8{cmd_pos[23]}}, cmd_pos};
                default:               reg_rdata <= 32'h0;
            endcase
        end
        else
            reg_rdata <= 32'h0;
    end

    // unassigned unlock reads as ON, several assigned terminals must all be ON
    always_ff @(posedge clk)
    begin
        if (rst)
            tool_functions_allowed <= 1'b1;
        else
            tool_functions_allowed <= ((filt.tool_terms & unlock_map) == unlock_map);
    end

    // motion may only start in position mode with the free input off
    assign may_start = pos_mode && !filt.free_run;
    assign any_start_level = filt.start | filt.home_start | filt.sequential_start | (|filt.direct_select_inputs)
                           | filt.jog_positive | filt.jog_negative;
    assign ms_no = direct_map[mcd_first(rise.direct_select_inputs) * 4 +: 4];

    // pick one request per cycle; home first, then start, sequential, direct, jog
    always_comb
    begin
        next_cmd = '0;
        next_cmd.torque_pct = `MCD_TORQUE_RST;
        if (may_start)
        begin
            if (rise.home_start)
            begin
                next_cmd.valid        = 1'b1;
                next_cmd.kind         = MCD_CMD_HOME;
                next_cmd.dir_positive = home_dir;
                next_cmd.speed        = home_speed;
                next_cmd.accel_ms     = home_accel;
                next_cmd.offset       = home_offset;
            end
            else if (rise.start)
            begin
                next_cmd.valid   = 1'b1;
                next_cmd.kind    = MCD_CMD_POSITION;
                next_cmd.data_no = filt.op_select;
            end
            else if (rise.sequential_start)
            begin
                next_cmd.valid   = 1'b1;
                next_cmd.kind    = MCD_CMD_SEQUENTIAL;
                next_cmd.data_no = seq_no;
            end
            else if (|rise.direct_select_inputs)
            begin
                next_cmd.valid   = 1'b1;
                next_cmd.kind    = MCD_CMD_DIRECT;
                next_cmd.data_no = ms_no;
            end
            else if (rise.jog_positive || rise.jog_negative)
            begin
                next_cmd.valid        = 1'b1;
                next_cmd.kind         = MCD_CMD_JOG;
                next_cmd.dir_positive = rise.jog_positive;
                next_cmd.speed        = jog_speed;
                next_cmd.accel_ms     = jog_accel;
                next_cmd.torque_pct   = jog_torque;
                next_cmd.travel       = jog_travel;
            end
        end
    end

    // request register; valid is a one-cycle pulse, the fields hold until the next one
    always_ff @(posedge clk)
    begin
        if (rst)
            motion_cmd <= '0;
        else
        begin
            motion_cmd.valid <= next_cmd.valid;
            if (next_cmd.valid)
                motion_cmd <= next_cmd;
        end
    end

    // the sequence number follows the last positioning number that ran
    always_ff @(posedge clk)
    begin
        if (rst)
            seq_no <= 4'h0;
        else if (next_cmd.valid && next_cmd.kind != MCD_CMD_HOME && next_cmd.kind != MCD_CMD_JOG)
            seq_no <= next_cmd.data_no + 4'h1;
    end

    // homing state: the origin counts once the homing move ends and the motor is still
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            home_active      <= 1'b0;
            home_established <= 1'b0;
        end
        else if (next_cmd.valid)
        begin
            home_active      <= (next_cmd.kind == MCD_CMD_HOME);
            home_established <= 1'b0; // any new move leaves the origin
        end
        else if (!pos_mode)
            home_active <= 1'b0;
        else if (home_active && motion_done && !motor_moving)
        begin
            home_active      <= 1'b0;
            home_established <= 1'b1;
        end
        else if (pload_ok)
            home_established <= 1'b1; // a preset also sets the origin
    end

    // sensor is only meaningful to the profile generator while homing
    always_ff @(posedge clk)
    begin
        if (rst)
            home_sensor_active <= 1'b0;
        else
            home_sensor_active <= home_active && filt.home_sensor;
    end

    // preset acts on the rising edge only, never during alarm or motion
    assign pload_ok = pos_mode && rise.position_load && !alarm_flag && !motor_moving;

    always_ff @(posedge clk)
    begin
        if (rst)
            cmd_pos <= `MCD_POS_RST;
        else if (pload_ok)
            cmd_pos <= preset_pos;
    end

    // mode-dependent status outputs; absent signals are held low
    always_ff @(posedge clk)
    begin
        if (rst)
            status_outs <= '0;
        else
        begin
            status_outs.ready                    <= pos_mode && !any_start_level && !filt.free_run && !alarm_flag
                                                    && !motor_moving;
            status_outs.home_position            <= pos_mode && home_established && !motor_moving;
            status_outs.end_done                 <= pos_mode && motion_done && !motor_moving;
            status_outs.torque_limit_reached     <= !compat_mode && torque_at_limit;
            status_outs.legacy_torque_limit_flag <= compat_mode && torque_at_limit;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_home_request;
        rise.home_start && may_start;
    endsequence

    sequence s_home_finish;
        home_active && motion_done && !motor_moving && !next_cmd.valid && pos_mode;
    endsequence

    property p_speed_mode_silent;
        !pos_mode |=> !motion_cmd.valid;
    endproperty
    a_speed_mode_silent: assert property (p_speed_mode_silent) else $error("command issued in speed mode");

    property p_free_blocks;
        filt.free_run |=> !motion_cmd.valid;
    endproperty
    a_free_blocks: assert property (p_free_blocks) else $error("command issued while free input on");

    property p_start_selected;
        (may_start && rise.start && !rise.home_start) |=>
            motion_cmd.valid && motion_cmd.kind == MCD_CMD_POSITION && motion_cmd.data_no == $past(filt.op_select);
    endproperty
    a_start_selected: assert property (p_start_selected) else $error("start did not run selected number");

    property p_home_start;
        s_home_request |=> motion_cmd.valid && motion_cmd.kind == MCD_CMD_HOME && motion_cmd.speed == $past(home_speed)
            ##1 !motion_cmd.valid;
    endproperty
    a_home_start: assert property (p_home_start) else $error("home request not issued as one pulse");

    property p_home_done;
        s_home_finish |=> home_established ##1 (status_outs.home_position || $past(motor_moving) || !$past(pos_mode));
    endproperty
    a_home_done: assert property (p_home_done) else $error("home position not flagged after homing");

    property p_unmapped_unlock;
        (unlock_map == 8'h00) |=> tool_functions_allowed;
    endproperty
    a_unmapped_unlock: assert property (p_unmapped_unlock) else $error("unmapped unlock not treated as on");

    property p_unlock_and;
        (unlock_map != 8'h00 && (filt.tool_terms & unlock_map) != unlock_map) |=> !tool_functions_allowed;
    endproperty
    a_unlock_and: assert property (p_unlock_and) else $error("unlock allowed with a mapped terminal off");

    property p_preset_load;
        pload_ok |=> cmd_pos == $past(preset_pos);
    endproperty
    a_preset_load: assert property (p_preset_load) else $error("preset not loaded on edge");

    property p_preset_blocked;
        (rise.position_load && (alarm_flag || motor_moving)) |=> $stable(cmd_pos);
    endproperty
    a_preset_blocked: assert property (p_preset_blocked) else $error("preset loaded during alarm or motion");

    property p_direct_map;
        (may_start && rise.direct_select_inputs[0] && !rise.home_start && !rise.start && !rise.sequential_start) |=>
            motion_cmd.kind == MCD_CMD_DIRECT && motion_cmd.data_no == $past(direct_map[3:0]);
    endproperty
    a_direct_map: assert property (p_direct_map) else $error("direct select used wrong number");

    property p_seq_next;
        (may_start && rise.sequential_start && !rise.home_start && !rise.start
            && (motion_cmd.kind == MCD_CMD_POSITION || motion_cmd.kind == MCD_CMD_SEQUENTIAL
            || motion_cmd.kind == MCD_CMD_DIRECT)) |=> motion_cmd.valid && motion_cmd.kind == MCD_CMD_SEQUENTIAL
            && motion_cmd.data_no == $past(motion_cmd.data_no) + 4'h1;
    endproperty
    a_seq_next: assert property (p_seq_next) else $error("sequential start did not advance");

    property p_mode_outputs;
        !pos_mode |=> !status_outs.ready && !status_outs.home_position && !status_outs.end_done;
    endproperty
    a_mode_outputs: assert property (p_mode_outputs) else $error("position-only output in speed mode");

endmodule : mcd_top

// ### test/mcd_host_model.sv
module mcd_host_model
    import mcd_pkg::*;
(
    input  wire logic   clk,
    output mcd_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // every terminal starts OFF, so no command can fire before the first drive
    initial pins = '0;

    // the controller updates its terminals just after an edge, like a plc scan
    task drive(input mcd_pins_type v);
        @(posedge clk);
        pins <= v;
    endtask : drive
endmodule : mcd_host_model

// ### test/tb_mcd_top.sv
module tb_mcd_top
    import mcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk, rst, alarm_flag, motor_moving, motion_done, torque_at_limit;
    logic [7:0]   reg_addr;
    logic [31:0]  reg_wdata, reg_rdata, d;
    logic         reg_write, reg_read, home_sensor_active, tool_functions_allowed, got;
    mcd_pins_type pins, base, p;
    mcd_cmd_type  motion_cmd, c;
    mcd_outs_type status_outs;
    int           n_mismatch, checks, i;
    // reset view of the map: address beside expected word, 0x3c is unmapped
    logic [39:0]  rows [12] = '{40'h04_0000012c, 40'h08_00000064, 40'h0c_00000000, 40'h10_00000001,
                                40'h14_0000012c, 40'h18_00000064, 40'h1c_00000064, 40'h20_00000001,
                                40'h24_00000000, 40'h28_00543210, 40'h3c_00000000, 40'h00_00000000};

    mcd_host_model i_host (.clk(clk), .pins(pins));

    mcd_top i_mcd_top (.clk(clk), .rst(rst), .pins(pins), .alarm_flag(alarm_flag), .motor_moving(motor_moving),
        .motion_done(motion_done), .torque_at_limit(torque_at_limit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .motion_cmd(motion_cmd),
        .home_sensor_active(home_sensor_active), .tool_functions_allowed(tool_functions_allowed),
        .status_outs(status_outs));

    // 20 MHz
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // wide enough for the field groups compared below; a whole packed command needs 92 bits
    task chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    task close_out;
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // press, catch any one-cycle command pulse, then release; the filter needs ~5 edges
    task fire(input mcd_pins_type v);
        got = 1'b0;
        i_host.drive(v);
        repeat (12)
        begin
            @(posedge clk);
            #1;
            if (motion_cmd.valid === 1'b1)
            begin
                got = 1'b1;
                c   = motion_cmd;
            end
        end
        i_host.drive(base);
        repeat (6) @(posedge clk);
    endtask : fire

    initial
    begin
        {rst, alarm_flag, motor_moving, motion_done, torque_at_limit, reg_write, reg_read} = 7'h40;
        {reg_addr, reg_wdata, base, n_mismatch, checks} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(tool_functions_allowed, 1'b1);
        chk(status_outs, '0);
        for (i = 0; i < 12; i++)
        begin
            rd(rows[i][39:32], d);
            chk(d, rows[i][31:0]);
        end
        // speed mode: a start must be ignored
        p = base;
        p.start = 1'b1;
        fire(p);
        chk(got, 1'b0);
        // position mode, tool unlock on terminals 0 and 1
        wr(8'h00, 32'h00000301);
        base.tool_terms = 8'h01;
        fire(base);
        chk(tool_functions_allowed, 1'b0);
        base.tool_terms = 8'h03;
        fire(base);
        chk(tool_functions_allowed, 1'b1);
        wr(8'h04, 32'h00001388);
        rd(8'h04, d);
        chk(d, 32'h00000fa0);
        // data number is chosen before start goes on
        base.op_select = 4'h7;
        fire(base);
        chk(got, 1'b0);
        p = base;
        p.start = 1'b1;
        fire(p);
        chk({got, c.kind, c.data_no}, {1'b1, MCD_CMD_POSITION, 4'h7});
        p = base;
        p.sequential_start = 1'b1;
        fire(p);
        chk({got, c.kind, c.data_no}, {1'b1, MCD_CMD_SEQUENTIAL, 4'h8});
        wr(8'h28, 32'h00543f10);
        p = base;
        p.direct_select_inputs = 6'h04;
        fire(p);
        chk({got, c.kind, c.data_no}, {1'b1, MCD_CMD_DIRECT, 4'hf});
        p = base;
        p.home_start = 1'b1;
        fire(p);
        chk({got, c.kind, c.speed, c.accel_ms, c.dir_positive, c.offset},
            {1'b1, MCD_CMD_HOME, 13'hfa0, 15'h064, 1'b1, 24'h000000});
        base.home_sensor = 1'b1;
        fire(base);
        chk(home_sensor_active, 1'b1);
        base.home_sensor = 1'b0;
        i_host.drive(base);
        motion_done <= 1'b1;
        for (i = 0; i < 10 && status_outs.home_position !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk(status_outs.home_position, 1'b1);
        chk(status_outs.end_done, 1'b1);
        if (i == 10)
            close_out;
        @(posedge clk);
        motion_done <= 1'b0;
        p = base;
        p.jog_positive = 1'b1;
        fire(p);
        chk({got, c.kind, c.dir_positive, c.speed, c.accel_ms, c.torque_pct, c.travel},
            {1'b1, MCD_CMD_JOG, 1'b1, 13'h12c, 15'h064, 8'h64, 23'h000001});
        p = base;
        p.jog_negative = 1'b1;
        fire(p);
        chk({got, c.kind, c.dir_positive}, {1'b1, MCD_CMD_JOG, 1'b0});
        p = base;
        p.free_run = 1'b1;
        p.start = 1'b1;
        fire(p);
        chk(got, 1'b0);
        // preset on a load edge, then refused under alarm and during motion
        wr(8'h24, 32'h00fffffb);
        p = base;
        p.position_load = 1'b1;
        fire(p);
        rd(8'h30, d);
        chk(d, 32'hfffffffb);
        wr(8'h24, 32'h00000009);
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk);
            {alarm_flag, motor_moving} <= 2'(2 - i);
            fire(p);
            rd(8'h30, d);
            chk(d, (i == 2) ? 32'h00000009 : 32'hfffffffb);
        end
        chk(status_outs.ready, 1'b1);
        @(posedge clk);
        torque_at_limit <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({status_outs.torque_limit_reached, status_outs.legacy_torque_limit_flag}, 2'b10);
        wr(8'h00, 32'h00000303);
        repeat (3) @(posedge clk);
        #1;
        chk({status_outs.torque_limit_reached, status_outs.legacy_torque_limit_flag}, 2'b01);
        close_out;
    end
endmodule : tb_mcd_top
